// *** verilog/vmcs_pkg.sv ***
// Package of constants and types for the video mode/color/status registers
// Overview of operation
// RULE1 - Six-bit write-only color select register, written at address 3D9.
// RULE2 - Color bits 0-2 give blue, green, red of the mode's colored area.
// RULE3 - Color bit 3 intensifies border, background or foreground per mode.
// RULE4 - Color bit 4: alternate palette in graphics, background set in text.
// RULE5 - Six-bit write-only mode control register, written at address 3D8.
// RULE6 - Mode bit 0 one gives 80x25 text, zero gives 40x25 text.
// RULE7 - Mode bit 1 one gives 320x200 graphics, zero gives text.
// RULE8 - Mode bit 2 one gives black-and-white, zero gives color output.
// RULE9 - Mode bit 3 gates video on; software turns it off to change modes.
// RULE10 - Mode bit 4 gives 640x200 graphics, foreground from color register.
// RULE11 - Mode bit 5 makes high background bit blink; zero gives 16 colors.
// RULE12 - Four-bit read-only status register at 3DA, returned on input cycle.
// RULE13 - Status bit 0 is one while buffer access cannot disturb the picture.
// RULE14 - Status bit 1 is pen latch, set by rising edge, cleared at reset.
// RULE15 - Any output cycle to 3DB clears the light-pen latch, data ignored; the code keeps it set when a pen edge comes in the same cycle.
// RULE16 - Status bit 2 shows raw light-pen switch, zero while switch is on.
// RULE17 - Status bit 3 is one during vertical retrace.
// RULE18 - Any output cycle to 3DC presets the light-pen latch.
// RULE19 - Addresses decoded from host I/O bus; data bits 6 and 7 ignored.
package vmcs_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int REG_W = 6;
    localparam int COLOR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 10'h3d8;
    localparam logic [ADDR_W-1:0] ADDR_COLOR = 10'h3d9;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 10'h3da;
    localparam logic [ADDR_W-1:0] ADDR_LP_CLR = 10'h3db;
    localparam logic [ADDR_W-1:0] ADDR_LP_SET = 10'h3dc;
    localparam logic [REG_W-1:0] MODE_RESET = 6'h00;
    localparam logic [REG_W-1:0] COLOR_RESET = 6'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [COLOR_W-1:0] COLOR_ZERO = 4'h0;
    localparam logic [3:0] STATUS_PAD = 4'h0;

    // Mode control register layout, bit 5 down to bit 0
    typedef struct packed {
        logic blink_en;
        logic hires_640;
        logic video_en;
        logic mono;
        logic gfx_320;
        logic text_80;
    } vmcs_mode_t;

    // Color select register layout, bit 5 down to bit 0
    typedef struct packed {
        logic spare;
        logic alt_set;
        logic intens;
        logic [2:0] rgb;
    } vmcs_color_t;

    // Status register layout, bit 3 down to bit 0
    typedef struct packed {
        logic vretrace;
        logic pen_switch;
        logic pen_latch;
        logic access_ok;
    } vmcs_status_t;

    // Complete module state
    typedef struct packed {
        vmcs_mode_t mode;
        vmcs_color_t color;
        logic pen_latch;
        logic pen_prev;
        logic [DATA_W-1:0] rdata;
        logic rack;
        logic [COLOR_W-1:0] border;
        logic [COLOR_W-1:0] gfx_bg;
        logic [COLOR_W-1:0] gfx_fg;
        logic alt_palette;
        logic text_bg_set;
    } vmcs_state_t;
endpackage : vmcs_pkg

// *** verilog/vmcs_regs.sv ***
// Mode, color select and status registers of the video adapter
`timescale 1ns/1ps
module vmcs_regs (
    input wire logic sys_clk_in, // 25 MHz bus clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic [9:0] io_addr_in, // I/O address
    input wire logic [7:0] io_wdata_in, // Write data
    input wire logic io_wr_in, // Output cycle strobe
    input wire logic io_rd_in, // Input cycle strobe
    input wire logic access_ok_in, // Buffer access safe
    input wire logic vretrace_in, // Vertical retrace
    input wire logic pen_trig_in, // Light pen trigger
    input wire logic pen_sw_b_in, // Pen switch, low=on
    output logic [7:0] io_rdata_out, // Read data
    output logic io_rack_out, // Read answer
    output logic text_80_out, // 80x25 text
    output logic gfx_320_out, // 320x200 graphics
    output logic mono_out, // Black-and-white
    output logic video_en_out, // Video gated on
    output logic hires_640_out, // 640x200 graphics
    output logic blink_en_out, // Blink attribute
    output logic [3:0] border_color_out, // 40-column text border IRGB
    output logic [3:0] gfx_bg_color_out, // 320 background IRGB
    output logic [3:0] gfx_fg_color_out, // 640 foreground IRGB
    output logic alt_palette_out, // Alternate set
    output logic text_bg_set_out, // Text background set
    output logic pen_latch_out // Light pen latch
);
    vmcs_pkg::vmcs_state_t st_reg;
    vmcs_pkg::vmcs_state_t st_next;
    vmcs_pkg::vmcs_status_t status;
    logic wr_mode;
    logic wr_color;
    logic wr_lp_clr;
    logic wr_lp_set;
    logic rd_status;
    logic pen_rise;
    logic is_gfx;
    logic is_text40;

    // Address decode of the host I/O bus
    assign wr_mode = io_wr_in && (io_addr_in == vmcs_pkg::ADDR_MODE); // RULE5
    assign wr_color = io_wr_in &&
        (io_addr_in == vmcs_pkg::ADDR_COLOR); // RULE1
    assign wr_lp_clr = io_wr_in &&
        (io_addr_in == vmcs_pkg::ADDR_LP_CLR); // RULE15
    assign wr_lp_set = io_wr_in &&
        (io_addr_in == vmcs_pkg::ADDR_LP_SET); // RULE18
    assign rd_status = io_rd_in &&
        (io_addr_in == vmcs_pkg::ADDR_STATUS); // RULE12
    assign pen_rise = pen_trig_in && !st_reg.pen_prev; // RULE14

    // Live status word
    always_comb begin
        status.access_ok = access_ok_in; // RULE13
        status.pen_latch = st_reg.pen_latch; // RULE14
        status.pen_switch = pen_sw_b_in; // RULE16
        status.vretrace = vretrace_in; // RULE17
    end

    // Next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.pen_prev = pen_trig_in;
        if (wr_mode) begin
            st_next.mode = io_wdata_in[vmcs_pkg::REG_W-1:0]; // RULE19
        end
        if (wr_color) begin
            st_next.color = io_wdata_in[vmcs_pkg::REG_W-1:0]; // RULE19
        end
        // Set sources win over the clear address
        if (pen_rise || wr_lp_set) begin
            st_next.pen_latch = 1'b1; // RULE14 RULE18
        end else if (wr_lp_clr) begin
            st_next.pen_latch = 1'b0; // RULE15
        end
        st_next.rack = rd_status;
        st_next.rdata = vmcs_pkg::DATA_ZERO;
        if (rd_status) begin
            st_next.rdata = {vmcs_pkg::STATUS_PAD, status}; // RULE12
        end
        is_gfx = st_next.mode.gfx_320 || st_next.mode.hires_640;
        is_text40 = !is_gfx && !st_next.mode.text_80;
        // Color roles follow the mode in force
        st_next.border = vmcs_pkg::COLOR_ZERO;
        st_next.gfx_bg = vmcs_pkg::COLOR_ZERO;
        st_next.gfx_fg = vmcs_pkg::COLOR_ZERO;
        if (is_text40) begin
            st_next.border = {st_next.color.intens,
                st_next.color.rgb}; // RULE2 RULE3
        end
        if (st_next.mode.gfx_320 && !st_next.mode.hires_640) begin
            st_next.gfx_bg = {st_next.color.intens,
                st_next.color.rgb}; // RULE2 RULE3
        end
        if (st_next.mode.hires_640) begin
            st_next.gfx_fg = {st_next.color.intens,
                st_next.color.rgb}; // RULE10
        end
        st_next.alt_palette = is_gfx && st_next.color.alt_set; // RULE4
        st_next.text_bg_set = !is_gfx && st_next.color.alt_set; // RULE4
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_reg <= '0;
            st_reg.mode <= vmcs_pkg::MODE_RESET;
            st_reg.color <= vmcs_pkg::COLOR_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign io_rdata_out = st_reg.rdata;
    assign io_rack_out = st_reg.rack;
    assign text_80_out = st_reg.mode.text_80; // RULE6
    assign gfx_320_out = st_reg.mode.gfx_320; // RULE7
    assign mono_out = st_reg.mode.mono; // RULE8
    assign video_en_out = st_reg.mode.video_en; // RULE9
    assign hires_640_out = st_reg.mode.hires_640; // RULE10
    assign blink_en_out = st_reg.mode.blink_en; // RULE11
    assign border_color_out = st_reg.border;
    assign gfx_bg_color_out = st_reg.gfx_bg;
    assign gfx_fg_color_out = st_reg.gfx_fg;
    assign alt_palette_out = st_reg.alt_palette;
    assign text_bg_set_out = st_reg.text_bg_set;
    assign pen_latch_out = st_reg.pen_latch;

    // Register writes take data bits 5..0
    a_mode_write: assert property (@(posedge sys_clk_in) // RULE5
        disable iff (!rst_b_in)
        wr_mode |=> {blink_en_out, hires_640_out, video_en_out, mono_out,
            gfx_320_out, text_80_out} == $past(io_wdata_in[5:0]))
        else $error("mode register not loaded");

    a_color_write: assert property (@(posedge sys_clk_in) // RULE1
        disable iff (!rst_b_in)
        wr_color |=> st_reg.color == $past(io_wdata_in[5:0]))
        else $error("color register not loaded");

    a_mode_other_addr: assert property (@(posedge sys_clk_in) // RULE19
        disable iff (!rst_b_in)
        !wr_mode |=> $stable(st_reg.mode))
        else $error("mode changed without its write");

    // Light-pen latch behaviour
    a_pen_edge_set: assert property (@(posedge sys_clk_in) // RULE14
        disable iff (!rst_b_in)
        !pen_trig_in ##1 pen_trig_in |=> pen_latch_out)
        else $error("pen edge did not set latch");

    a_pen_clear: assert property (@(posedge sys_clk_in) // RULE15
        disable iff (!rst_b_in)
        wr_lp_clr && !pen_rise |=> !pen_latch_out)
        else $error("clear address did not clear latch");

    a_pen_preset: assert property (@(posedge sys_clk_in) // RULE18
        disable iff (!rst_b_in)
        wr_lp_set |=> pen_latch_out)
        else $error("preset address did not set latch");

    a_pen_hold: assert property (@(posedge sys_clk_in) // RULE14
        disable iff (!rst_b_in)
        pen_latch_out && !wr_lp_clr |=> pen_latch_out)
        else $error("pen latch dropped by itself");

    // Status reads
    a_status_read: assert property (@(posedge sys_clk_in) // RULE12
        disable iff (!rst_b_in)
        rd_status |=> io_rack_out && io_rdata_out ==
            {4'h0, $past(vretrace_in), $past(pen_sw_b_in),
            $past(pen_latch_out), $past(access_ok_in)})
        else $error("status read data wrong");

    a_read_unmapped: assert property (@(posedge sys_clk_in) // RULE12
        disable iff (!rst_b_in)
        !rd_status |=> !io_rack_out && io_rdata_out == 8'h00)
        else $error("answer to unmapped read");

    // Color roles
    a_border_text40: assert property (@(posedge sys_clk_in) // RULE2
        disable iff (!rst_b_in)
        !text_80_out && !gfx_320_out && !hires_640_out |->
            border_color_out == st_reg.color[3:0])
        else $error("border color not from color register");

    a_fg_hires: assert property (@(posedge sys_clk_in) // RULE10
        disable iff (!rst_b_in)
        hires_640_out |-> gfx_fg_color_out == st_reg.color[3:0]
            && border_color_out == 4'h0)
        else $error("640 foreground color wrong");

    a_alt_palette: assert property (@(posedge sys_clk_in) // RULE4
        disable iff (!rst_b_in)
        alt_palette_out |-> (gfx_320_out || hires_640_out)
            && !text_bg_set_out)
        else $error("alternate palette outside graphics");

    a_text_bg_set: assert property (@(posedge sys_clk_in) // RULE4
        disable iff (!rst_b_in)
        !gfx_320_out && !hires_640_out |->
            text_bg_set_out == st_reg.color.alt_set && !alt_palette_out)
        else $error("text background set wrong");

    a_alt_in_gfx: assert property (@(posedge sys_clk_in) // RULE4
        disable iff (!rst_b_in)
        gfx_320_out || hires_640_out |->
            alt_palette_out == st_reg.color.alt_set && !text_bg_set_out)
        else $error("alternate palette wrong in graphics");

    a_bg_gfx320: assert property (@(posedge sys_clk_in) // RULE2
        disable iff (!rst_b_in)
        gfx_320_out && !hires_640_out |->
            gfx_bg_color_out == st_reg.color[3:0])
        else $error("320 background color wrong");

    a_bg_intensity: assert property (@(posedge sys_clk_in) // RULE3
        disable iff (!rst_b_in)
        gfx_320_out && !hires_640_out |->
            gfx_bg_color_out[3] == st_reg.color.intens)
        else $error("320 background intensity wrong");

    // Each color role stays dark outside the mode that owns it
    a_border_other: assert property (@(posedge sys_clk_in) // RULE6
        disable iff (!rst_b_in)
        text_80_out || gfx_320_out || hires_640_out |->
            border_color_out == 4'h0)
        else $error("border color outside 40-column text");

    a_bg_other: assert property (@(posedge sys_clk_in) // RULE7
        disable iff (!rst_b_in)
        !gfx_320_out || hires_640_out |-> gfx_bg_color_out == 4'h0)
        else $error("background color outside 320 graphics");

    a_fg_other: assert property (@(posedge sys_clk_in) // RULE10
        disable iff (!rst_b_in)
        !hires_640_out |-> gfx_fg_color_out == 4'h0)
        else $error("foreground color outside 640 graphics");

    // Single mode bits follow their data bits
    a_video_gate: assert property (@(posedge sys_clk_in) // RULE9
        disable iff (!rst_b_in)
        wr_mode |=> video_en_out == $past(io_wdata_in[3]))
        else $error("video gate not taken from bit 3");

    a_mono_select: assert property (@(posedge sys_clk_in) // RULE8
        disable iff (!rst_b_in)
        wr_mode |=> mono_out == $past(io_wdata_in[2]))
        else $error("black-and-white not taken from bit 2");

    a_color_other_addr: assert property (@(posedge sys_clk_in) // RULE19
        disable iff (!rst_b_in)
        !wr_color |=> $stable(st_reg.color))
        else $error("color changed without its write");

    // Set sources beat the clear address on a shared edge
    a_set_wins: assert property (@(posedge sys_clk_in) // RULE14
        disable iff (!rst_b_in)
        pen_rise && wr_lp_clr |=> pen_latch_out)
        else $error("clear beat a pen edge");

    a_pen_no_source: assert property (@(posedge sys_clk_in) // RULE14
        disable iff (!rst_b_in)
        !pen_latch_out && !pen_rise && !wr_lp_set |=> !pen_latch_out)
        else $error("pen latch set with no source");

    // Status bits one by one, and answers only after a status read
    a_access_bit: assert property (@(posedge sys_clk_in) // RULE13
        disable iff (!rst_b_in)
        rd_status |=> io_rdata_out[0] == $past(access_ok_in))
        else $error("access bit wrong");

    a_latch_readback: assert property (@(posedge sys_clk_in) // RULE14
        disable iff (!rst_b_in)
        rd_status |=> io_rdata_out[1] == $past(pen_latch_out))
        else $error("pen latch bit wrong");

    a_switch_raw: assert property (@(posedge sys_clk_in) // RULE16
        disable iff (!rst_b_in)
        rd_status |=> io_rdata_out[2] == $past(pen_sw_b_in))
        else $error("pen switch bit wrong");

    a_retrace_bit: assert property (@(posedge sys_clk_in) // RULE17
        disable iff (!rst_b_in)
        rd_status |=> io_rdata_out[3] == $past(vretrace_in))
        else $error("retrace bit wrong");

    a_status_hi_zero: assert property (@(posedge sys_clk_in) // RULE12
        disable iff (!rst_b_in)
        io_rack_out |-> io_rdata_out[7:4] == 4'h0)
        else $error("status upper bits not zero");

    a_rack_source: assert property (@(posedge sys_clk_in) // RULE12
        disable iff (!rst_b_in)
        io_rack_out |-> $past(io_rd_in)
            && $past(io_addr_in) == vmcs_pkg::ADDR_STATUS)
        else $error("read answer without status read");

    a_write_no_rack: assert property (@(posedge sys_clk_in) // RULE12
        disable iff (!rst_b_in)
        io_wr_in && !io_rd_in |=> !io_rack_out)
        else $error("read answer after a write");

    // Main scenarios
    c_mode_write: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) wr_mode ##1 video_en_out);
    c_pen_cycle: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) pen_rise ##1 wr_lp_clr ##1 !pen_latch_out);
    c_status_read: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) rd_status ##1 io_rdata_out[1]);
    c_set_clear_race: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) pen_rise && wr_lp_clr);
    c_hires_fg: cover property (@(posedge sys_clk_in)
        disable iff (!rst_b_in) hires_640_out && gfx_fg_color_out != 4'h0);
endmodule : vmcs_regs

// *** testbench/vmcs_far_model.sv ***
// Model of the raster timing and light pen behind the status register
`timescale 1ns/1ps
module vmcs_far_model (
    input wire logic clk_in, // Bus clock
    input wire logic [3:0] want_in, // {retrace,switch_b,trigger,access_ok}
    output logic access_ok_out, // Buffer access safe
    output logic vretrace_out, // Vertical retrace
    output logic pen_trig_out, // Light pen trigger
    output logic pen_sw_b_out // Pen switch, low=on
);
    logic [3:0] held;
    // Quiet at time zero; wanted levels are taken on the edge, shown 1 ns on
    initial begin
        {vretrace_out, pen_sw_b_out, pen_trig_out, access_ok_out} = 4'h0;
        forever begin
            @(posedge clk_in);
            held = want_in;
            #1;
            {vretrace_out, pen_sw_b_out, pen_trig_out, access_ok_out} = held;
        end
    end
endmodule : vmcs_far_model

// *** testbench/tb.sv ***
// Self-checking bench for the mode, color and status registers
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] data;
        logic [19:0] exp;
    } vmcs_row_t;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [9:0] io_addr_in = 10'h000;
    logic [7:0] io_wdata_in = 8'h00;
    logic io_wr_in = 1'b0;
    logic io_rd_in = 1'b0;
    logic [3:0] want = 4'h0;
    logic ok_w, vr_w, trig_w, sw_w, rack, latch;
    logic [7:0] rdata;
    wire logic [19:0] got; // {mode,border,bg,fg,alt,text set}
    int err_count = 0;
    int check_count = 0;
    // Writes in order, each with every mode and role output it must give
    vmcs_row_t rows [11] = '{
        '{10'h3d8, 8'hc0, 20'h0_0000},
        '{10'h3d9, 8'hff, 20'h0_3c01},
        '{10'h3d8, 8'h0a, 20'h2_83c2},
        '{10'h3d9, 8'h05, 20'h2_8140},
        '{10'h3d8, 8'h10, 20'h4_0014},
        '{10'h3d8, 8'h21, 20'h8_4000},
        '{10'h3d8, 8'h04, 20'h1_1400},
        '{10'h3d9, 8'h15, 20'h1_1401},
        '{10'h3d8, 8'h3f, 20'hf_c016},
        '{10'h3d7, 8'hff, 20'hf_c016},
        '{10'h3da, 8'h00, 20'hf_c016}
    };
    vmcs_far_model vmcs_far_model_inst (.clk_in(sys_clk_in), .want_in(want),
        .access_ok_out(ok_w), .vretrace_out(vr_w), .pen_trig_out(trig_w),
        .pen_sw_b_out(sw_w));
    vmcs_regs vmcs_regs_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
        .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .access_ok_in(ok_w),
        .vretrace_in(vr_w), .pen_trig_in(trig_w), .pen_sw_b_in(sw_w),
        .io_rdata_out(rdata), .io_rack_out(rack), .text_80_out(got[14]),
        .gfx_320_out(got[15]), .mono_out(got[16]), .video_en_out(got[17]),
        .hires_640_out(got[18]), .blink_en_out(got[19]),
        .border_color_out(got[13:10]), .gfx_bg_color_out(got[9:6]),
        .gfx_fg_color_out(got[5:2]), .alt_palette_out(got[1]),
        .text_bg_set_out(got[0]), .pen_latch_out(latch));
    // 25 MHz bus clock
    always #20 sys_clk_in = ~sys_clk_in;
    // Counts a comparison and reports a mismatch at once
    task check(input string what, input logic [19:0] e, input logic [19:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // One output cycle; registers show the value after the taking edge
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk_in) #1;
        io_wr_in = 1'b1;
        io_addr_in = a;
        io_wdata_in = d;
        @(posedge sys_clk_in) #1;
        io_wr_in = 1'b0;
    endtask : wr
    // One input cycle; the answer stands for the cycle after the edge
    task rd(input logic [9:0] a, input logic [8:0] e);
        @(posedge sys_clk_in) #1;
        io_rd_in = 1'b1;
        io_addr_in = a;
        @(posedge sys_clk_in) #1;
        io_rd_in = 1'b0;
        check("read answer", {11'h000, e}, {11'h000, rack, rdata});
    endtask : rd
    // Prints the counts and the verdict, then ends the run
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    // Cuts a hang short well past the expected run length
    initial begin
        #(40 * 4000);
        err_count++;
        wrap_up();
    end
    // Main sequence: reset, table of writes, then status and pen cases
    initial begin
        repeat (20) @(posedge sys_clk_in);
        #1 rst_b_in = 1'b1;
        check("reset", 20'h0_0000, {got[19:1], latch});
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            check("row", rows[i].exp, got);
        end
        want = 4'hd;
        repeat (3) @(posedge sys_clk_in);
        rd(10'h3da, 9'h10d);
        want = 4'h0;
        repeat (3) @(posedge sys_clk_in);
        rd(10'h3da, 9'h100);
        want = 4'h6;
        repeat (4) @(posedge sys_clk_in) #1;
        check("pen latch", 20'h0_0001, {19'h0_0000, latch});
        rd(10'h3da, 9'h106);
        wr(10'h3db, 8'h5a);
        check("pen clear", 20'h0_0000, {19'h0_0000, latch});
        wr(10'h3dc, 8'h00);
        check("pen preset", 20'h0_0001, {19'h0_0000, latch});
        rd(10'h3d8, 9'h000);
        rd(10'h3d9, 9'h000);
        want = 4'h0;
        repeat (3) @(posedge sys_clk_in);
        wr(10'h3db, 8'h00);
        check("pen idle", 20'h0_0000, {19'h0_0000, latch});
        // Pen edge and clear address meet on one edge: the set must win
        want = 4'h2;
        wr(10'h3db, 8'h00);
        check("set wins", 20'h0_0001, {19'h0_0000, latch});
        want = 4'h0;
        repeat (3) @(posedge sys_clk_in);
        #1 rst_b_in = 1'b0;
        @(posedge sys_clk_in) #1;
        check("second reset", 20'h0_0000, {got[19:1], latch});
        rst_b_in = 1'b1;
        wr(10'h3d8, 8'h08);
        check("after reset", 20'h2_0000, got);
        wrap_up();
    end
endmodule : tb
